// [src/nine_bit_pkg.sv]
// package for the nine-bit host port: offsets, codes, bit positions, types
// assumes one system clock drives the host port and the card side alike
package nine_bit_pkg;

   // ------------------------------------------------------------
   // window offsets
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_RX = 4'h0;
   localparam logic [3:0] OFS_TX = 4'h1;
   localparam logic [3:0] OFS_HS = 4'h2;
   localparam logic [3:0] OFS_CMD = 4'h3;
   localparam logic [3:0] OFS_TCR = 4'h8;
   localparam logic [3:0] OFS_TCR_LAST = 4'hB;
   localparam logic [3:0] OFS_TSR = 4'hC;
   localparam logic [3:0] OFS_TSR_LAST = 4'hF;
   localparam int WIN_BITS = 4;

   // ------------------------------------------------------------
   // base addresses chosen by the switch
   // ------------------------------------------------------------
   localparam logic [15:0] BASE_CARD1 = 16'h2A20;
   localparam logic [15:0] BASE_CARD2 = 16'h2A30;

   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_INIT = 8'hBC;
   localparam logic [7:0] CMD_TIE_SET = 8'h05;
   localparam logic [7:0] CMD_TIE_CLR = 8'h04;
   localparam logic [7:0] CMD_RIE_SET = 8'h09;
   localparam logic [7:0] CMD_RIE_CLR = 8'h08;

   // ------------------------------------------------------------
   // bit positions and reset values
   // ------------------------------------------------------------
   localparam int HS_TX_RDY = 0;
   localparam int HS_TIE = 2;
   localparam int HS_RX_RDY = 3;
   localparam int HS_RIE = 4;
   localparam int HS_RX9 = 7;
   localparam int TCR_TX9 = 4;
   localparam int TSR_CARD_IRQ = 7;
   localparam logic [7:0] TCR_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } card_word_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } io_req_t;

endpackage

// [src/nine_bit_host_port.sv]
// host port of the sound card: 16-byte i/o window, nine-bit words both ways
// assumes io_req is synchronous to clock, rd/wr one-cycle pulses,
// and the card side is logic on the same clock
//
// How it works
// - the card answers sixteen contiguous addresses from its base
// - switch off/on picks base 2A20, on/on picks base 2A30
// - offsets 9 to B mirror the total control register
// - offsets D to F mirror the total status register
// - writing BC to the command register initialises the port
// - reading offset 0 returns received data and clears receive-ready
// - writing offset 1 while the port is empty captures data and clears transmit-ready
// - sent ninth bit comes from total control bit 4 at data write
// - writes to the handshake port leave both enables unchanged
// - transmit-ready is 0 at reset, 1 when enabled and port empty
// - receive-ready is 0 at reset, shows unread data when enabled
// - handshake bits 2 and 4 read back the two enables
// - handshake bit 7 shows the ninth bit of the card word
// - commands 05/04 set/clear transmit enable, 09/08 receive enable
// - each ready interrupt is enabled by its own enable bit
// - ninth bit 1 marks a card message, 0 plain data
// - total control register at offset 8 holds the sent ninth bit
// - card-wide status bit is 1 while a ready source requests
module nine_bit_host_port
   import nine_bit_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [1:0] address_select_switch,
   input wire io_req_t io_req,
   output logic [7:0] io_rdata,
   output logic io_sel,
   input wire logic card_rx_valid,
   input wire card_word_t card_rx_word,
   output logic card_rx_full,
   output card_word_t card_tx_word,
   output logic card_tx_valid,
   input wire logic card_tx_take,
   output logic port_irq
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (ADDR_W != 16) begin : g_bad_width
      $error("nine_bit_host_port: only a 16-bit i/o address is served");
   end

   // ------------------------------------------------------------
   // reset release and switch synchroniser
   // ------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_r;
   logic [1:0] sw_meta_r;
   logic [1:0] sw_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         sw_meta_r <= 2'h0;
         sw_r <= 2'h0;
      end else begin
         sw_meta_r <= address_select_switch;
         sw_r <= sw_meta_r;
      end
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // switch bit 0 is position 1, bit 1 position 2, 1 = on;
   // position 2 off leaves the card off the bus altogether
   wire base_ok = sw_r[1];
   wire [15:0] base_addr = sw_r[0] ? BASE_CARD2 : BASE_CARD1;
   wire win_hit = base_ok &&
      (io_req.addr[15:WIN_BITS] == base_addr[15:WIN_BITS]);
   wire [3:0] ofs = io_req.addr[WIN_BITS-1:0];
   wire rd_hit = win_hit && io_req.rd;
   wire wr_hit = win_hit && io_req.wr;
   wire tcr_sel = (ofs >= OFS_TCR) && (ofs <= OFS_TCR_LAST);
   wire tsr_sel = (ofs >= OFS_TSR) && (ofs <= OFS_TSR_LAST);
   wire rd_rx = rd_hit && (ofs == OFS_RX);
   wire wr_tx = wr_hit && (ofs == OFS_TX);
   wire wr_cmd = wr_hit && (ofs == OFS_CMD);
   wire wr_tcr = wr_hit && tcr_sel;

   // ------------------------------------------------------------
   // port state
   // ------------------------------------------------------------
   logic tie_r;
   logic rie_r;
   logic rx_full_r;
   logic tx_full_r;
   card_word_t rx_word_r;
   card_word_t tx_word_r;
   logic [7:0] tcr_r;
   logic [7:0] rdata_r;
   logic sel_r;
   logic irq_r;

   wire cmd_init = wr_cmd && (io_req.wdata == CMD_INIT);
   // writes at the handshake offset touch nothing: no decode for them
   wire tie_set = wr_cmd && (io_req.wdata == CMD_TIE_SET);
   wire tie_clr = wr_cmd && (io_req.wdata == CMD_TIE_CLR);
   wire rie_set = wr_cmd && (io_req.wdata == CMD_RIE_SET);
   wire rie_clr = wr_cmd && (io_req.wdata == CMD_RIE_CLR);

   wire tx_ready = tie_r && !tx_full_r;
   wire rx_ready = rie_r && rx_full_r;
   wire irq_nxt_src = tx_ready || rx_ready;

   // a host write while busy is dropped so the card word is never torn
   wire tx_load = wr_tx && !tx_full_r && !cmd_init;
   wire rx_load = card_rx_valid && !rx_full_r;

   // set wins over clear for the receive full flag; for the transmit full flag init blocks the set
   wire tx_full_nxt = tx_load ||
      (tx_full_r && !card_tx_take && !cmd_init);
   wire rx_full_nxt = rx_load ||
      (rx_full_r && !rd_rx && !cmd_init);
   wire tie_nxt = tie_set || (tie_r && !tie_clr && !cmd_init);
   wire rie_nxt = rie_set || (rie_r && !rie_clr && !cmd_init);

   wire [7:0] hs_value = {rx_word_r.ninth, 2'b00, rie_r, rx_ready, tie_r,
      1'b0, tx_ready};
   wire [7:0] tsr_value = {irq_nxt_src, 7'h00};

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = RDATA_RESET;
      if (ofs == OFS_RX)
         rd_mux = rx_word_r.data;
      else if (ofs == OFS_HS)
         rd_mux = hs_value;
      else if (tcr_sel)
         rd_mux = tcr_r;
      else if (tsr_sel)
         rd_mux = tsr_value;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         tie_r <= 1'b0;
         rie_r <= 1'b0;
         rx_full_r <= 1'b0;
         tx_full_r <= 1'b0;
      end else begin
         tie_r <= tie_nxt;
         rie_r <= rie_nxt;
         rx_full_r <= rx_full_nxt;
         tx_full_r <= tx_full_nxt;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rx_word_r <= '0;
         tx_word_r <= '0;
         tcr_r <= TCR_RESET;
      end else begin
         if (rx_load)
            rx_word_r <= card_rx_word;
         if (tx_load)
            tx_word_r <= {tcr_r[TCR_TX9], io_req.wdata};
         if (wr_tcr)
            tcr_r <= io_req.wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rdata_r <= RDATA_RESET;
         sel_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         rdata_r <= rd_hit ? rd_mux : RDATA_RESET;
         sel_r <= rd_hit;
         irq_r <= irq_nxt_src;
      end
   end

   assign io_rdata = rdata_r;
   assign io_sel = sel_r;
   assign card_rx_full = rx_full_r;
   assign card_tx_word = tx_word_r;
   assign card_tx_valid = tx_full_r;
   assign port_irq = irq_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_sync_r);

   a_rx_read_clears: assert property (
      rd_rx && !rx_load |=> !rx_full_r)
      else $error("receive data read did not clear receive flag");

   a_rx_read_data: assert property (
      rd_rx |=> io_sel && io_rdata == $past(rx_word_r.data))
      else $error("receive data read returned wrong byte");

   a_tx_write_clears: assert property (
      wr_tx && tie_r && !tx_full_r && !cmd_init |=> !tx_ready)
      else $error("transmit write left transmit-ready set");

   a_tx_ninth_bit: assert property (
      tx_load |=> card_tx_word == {$past(tcr_r[TCR_TX9]),
         $past(io_req.wdata)})
      else $error("sent word not paired with control bit 4");

   a_hs_write_no_enable: assert property (
      wr_hit && ofs == OFS_HS |=> $stable(tie_r) && $stable(rie_r))
      else $error("handshake write changed an enable");

   a_cmd_enables: assert property (
      (tie_set |=> tie_r) and (tie_clr |=> !tie_r) and
      (rie_set |=> rie_r) and (rie_clr |=> !rie_r))
      else $error("enable command had no effect");

   a_init_clears: assert property (
      cmd_init |=> !tie_r && !rie_r && !card_tx_valid)
      else $error("init command left port state");

   a_hs_readback: assert property (
      rd_hit && ofs == OFS_HS |=> io_rdata[HS_TIE] == $past(tie_r) &&
         io_rdata[HS_RIE] == $past(rie_r) &&
         io_rdata[HS_RX9] == $past(rx_word_r.ninth))
      else $error("handshake read did not show enables");

   a_irq_follows: assert property (
      (tx_ready || rx_ready) |=> port_irq ##0 1'b1)
      else $error("port interrupt missing while ready flag enabled");

   a_irq_drops: assert property (
      !tx_ready && !rx_ready |=> !port_irq)
      else $error("port interrupt without enabled ready flag");

   a_tcr_mirror: assert property (
      rd_hit && tcr_sel |=> io_rdata == $past(tcr_r))
      else $error("control mirror read wrong");

   a_tsr_mirror: assert property (
      rd_hit && tsr_sel |=> io_rdata[TSR_CARD_IRQ] == $past(irq_nxt_src))
      else $error("status mirror read wrong");

   c_host_to_card: cover property (tx_load ##[1:20] card_tx_take);
   c_card_to_host: cover property (rx_load ##[1:20] rd_rx);
   c_both_ready: cover property (tx_ready && rx_ready);

endmodule

// [verification/card_model.sv]
// card-side model: offers nine-bit words and takes sent words
// assumes words are offered one at a time by the bench
module card_model
   import nine_bit_pkg::*;
(
   input wire logic clock,
   input wire logic card_rx_full,
   input wire logic card_tx_valid,
   input wire card_word_t card_tx_word,
   output logic card_rx_valid,
   output card_word_t card_rx_word,
   output logic card_tx_take
);
   timeunit 1ns;
   timeprecision 100ps;
   int take_wait = 0;
   int hold = 0;
   card_word_t last_tx;
   initial begin
      card_rx_valid = 1'b0;
      card_rx_word = 9'h1FF;
      card_tx_take = 1'b0;
      last_tx = 9'h000;
   end
   // word held until a cycle with the holding register free
   task automatic offer(input card_word_t w);
      int i;
      @(posedge clock) #1;
      card_rx_valid = 1'b1;
      card_rx_word = w;
      for (i = 0; i < 200 && card_rx_full !== 1'b0; i++) begin
         @(posedge clock) #1;
      end
      @(posedge clock) #1;
      card_rx_valid = 1'b0;
      // released bus shows the inverse, not a stale copy
      card_rx_word = ~w;
   endtask
   // slow take stretches the busy time seen by the host
   always @(posedge clock) begin
      #1;
      if (card_tx_take) begin
         card_tx_take = 1'b0;
      end else if (card_tx_valid !== 1'b1) begin
         hold = take_wait;
      end else if (hold > 0) begin
         hold--;
      end else begin
         card_tx_take = 1'b1;
         last_tx = card_tx_word;
      end
   end
endmodule

// [verification/tb_top.sv]
// bench for the nine-bit host port: register tasks and card traffic
// assumes the card model drives the card side of the port
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import nine_bit_pkg::*;
   logic clock, rst_n, sel, rx_valid, rx_full, tx_valid, tx_take, irq;
   logic [1:0] sw;
   logic [7:0] rdata;
   logic [15:0] base;
   io_req_t req;
   card_word_t rx_word, tx_word;
   int mismatches = 0;
   int checked = 0;
   nine_bit_host_port uut (.clock(clock), .rst_n(rst_n),
      .address_select_switch(sw), .io_req(req), .io_rdata(rdata),
      .io_sel(sel), .card_rx_valid(rx_valid), .card_rx_word(rx_word),
      .card_rx_full(rx_full), .card_tx_word(tx_word),
      .card_tx_valid(tx_valid), .card_tx_take(tx_take), .port_irq(irq));
   card_model card (.clock(clock), .card_rx_full(rx_full),
      .card_tx_valid(tx_valid), .card_tx_word(tx_word),
      .card_rx_valid(rx_valid), .card_rx_word(rx_word),
      .card_tx_take(tx_take));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task tally_and_finish;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] ofs, input logic [7:0] d);
      @(posedge clock) #1;
      req = '{rd: 1'b0, wr: 1'b1, addr: base + {12'h000, ofs}, wdata: d};
      @(posedge clock) #1;
      req.wr = 1'b0;
   endtask
   // expected value is {io_sel, io_rdata}, answered one cycle later
   task rd(input logic [3:0] ofs, input logic [8:0] exp);
      @(posedge clock) #1;
      req.rd = 1'b1;
      req.addr = base + {12'h000, ofs};
      @(posedge clock) #1;
      req.rd = 1'b0;
      chk({sel, rdata}, exp);
   endtask
   task automatic wait_lvl(ref logic s, input logic v);
      int i;
      for (i = 0; i < 100 && s !== v; i++) @(posedge clock) #1;
      if (s !== v) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, s, v);
         tally_and_finish;
      end
   endtask
   task note(input string s);
      $display("test %s done", s);
   endtask
   // ------------------------------------------------------------
   // clock and sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      rst_n = 1'b0;
      sw = 2'b10;
      base = BASE_CARD1;
      req = '0;
      repeat (12) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clock);
      rd(OFS_HS, 9'h100);
      rd(OFS_TCR, 9'h100);
      wr(OFS_CMD, CMD_TIE_SET);
      rd(OFS_HS, 9'h105);
      chk({8'h00, irq}, 9'h001);
      rd(OFS_TSR, 9'h180);
      rd(4'hF, 9'h180);
      wr(OFS_HS, 8'h00);
      rd(OFS_HS, 9'h105);
      note("enables");
      wr(OFS_TCR, 8'h10);
      rd(4'hB, 9'h110);
      card.take_wait = 4;
      wr(OFS_TX, 8'hA5);
      rd(OFS_HS, 9'h104);
      wait_lvl(tx_valid, 1'b0);
      chk(card.last_tx, 9'h1A5);
      rd(OFS_HS, 9'h105);
      // a second word while the first still waits must be dropped
      card.take_wait = 8;
      wr(OFS_TX, 8'h11);
      wr(OFS_TX, 8'h22);
      wait_lvl(tx_valid, 1'b0);
      chk(card.last_tx, 9'h111);
      note("transmit");
      wr(OFS_CMD, CMD_TIE_CLR);
      wr(OFS_CMD, CMD_RIE_SET);
      rd(OFS_HS, 9'h110);
      chk({8'h00, irq}, 9'h000);
      card.offer(9'h13C);
      wait_lvl(rx_full, 1'b1);
      rd(OFS_HS, 9'h198);
      rd(OFS_RX, 9'h13C);
      // ninth bit stays with the held word after the read
      rd(OFS_HS, 9'h190);
      card.offer(9'h0C3);
      wait_lvl(rx_full, 1'b1);
      rd(OFS_HS, 9'h118);
      chk({8'h00, irq}, 9'h001);
      rd(OFS_RX, 9'h1C3);
      note("receive");
      wr(OFS_CMD, CMD_TIE_SET);
      card.offer(9'h055);
      wr(OFS_CMD, CMD_RIE_CLR);
      rd(OFS_HS, 9'h105);
      wr(OFS_CMD, CMD_INIT);
      rd(OFS_HS, 9'h100);
      chk({8'h00, rx_full}, 9'h000);
      note("init");
      sw = 2'b11;
      repeat (4) @(posedge clock);
      rd(OFS_TCR, 9'h000);
      base = BASE_CARD2;
      rd(OFS_TCR, 9'h110);
      rd(4'h7, 9'h100);
      sw = 2'b01;
      repeat (4) @(posedge clock);
      rd(OFS_TCR, 9'h000);
      note("decode");
      tally_and_finish;
   end
endmodule
